/* File: asr_pkg.sv */
// Package: constants, timing counts and state encoding for the asynchronous SRAM host
// Notes on behaviour
// - Read: selected, output enable low, write enable held high throughout.
// - Every read or write cycle lasts at least the grade cycle time.
// - Address must be valid no later than the select is asserted.
// - Address stands at least the grade minimum before the write ends.
// - Write pulse lasts at least the grade minimum, 12 to 20 ns.
// - Write data is stable at least the grade minimum before the write ends.
package asr_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int MEM_WORDS = 131072;
	localparam int TMR_W = 8;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_NS = 10;
	// Slowest grade figures, so any grade of the part is met
	localparam int T_CYCLE_NS = 35;
	localparam int T_ACCESS_NS = 35;
	localparam int T_WR_PULSE_NS = 20;
	localparam int T_ADDR_END_NS = 20;
	localparam int T_DATA_SETUP_NS = 11;
	localparam int T_FLOAT_NS = 8;
	// Least times, rounded up to whole cycles
	localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_PULSE_CYC = (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_END_CYC = (T_ADDR_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_SETUP_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Derived phase lengths in cycles
	localparam int READ_CYC = ACCESS_CYC + SYNC_STAGES;
	localparam int WE_LOW_A = (WR_PULSE_CYC > DATA_SETUP_CYC) ? WR_PULSE_CYC : DATA_SETUP_CYC;
	localparam int WE_LOW_CYC = (WE_LOW_A > ADDR_END_CYC) ? WE_LOW_A : ADDR_END_CYC;
	localparam int WR_REST_CYC = (CYCLE_CYC > WE_LOW_CYC + 1) ? CYCLE_CYC - WE_LOW_CYC : 1;
	localparam int TURN_CYC = (FLOAT_CYC > 1) ? FLOAT_CYC : 1;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_READ    = 3'b001,
		ST_WR_LOW  = 3'b010,
		ST_WR_HIGH = 3'b011,
		ST_TURN    = 3'b100
	} asr_state_e;
endpackage

/* File: asr_timer_if.sv */
// Interface: phase timer load and expiry between the host sequencer and its timer
`timescale 1ns/1ps
interface asr_timer_if import asr_pkg::*; ();
	logic             load;
	logic [TMR_W-1:0] loadValue;
	logic             expired;
	modport ctrl  (output load, output loadValue, input expired);
	modport timer (input load, input loadValue, output expired);
endinterface

/* File: asr_timer.sv */
// Module: down-counter that times each pin phase of the host
`timescale 1ns/1ps
module asr_timer import asr_pkg::*; (
	// Clock and reset
	input wire logic   sys_clk,
	input wire logic   rstSyncN,
	// Timer control
	asr_timer_if.timer tmr
);
	logic [TMR_W-1:0] count_reg;

	// Load wins over counting so a phase starts from its full length
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			count_reg <= 8'h00;
		end else if (tmr.load) begin
			count_reg <= tmr.loadValue;
		end else if (count_reg != 8'h00) begin
			count_reg <= count_reg - 8'h01;
		end
	end

	assign tmr.expired = (count_reg == 8'h00);
endmodule

/* File: asr_host.sv */
// Module: host controller driving a 128K x 8 asynchronous static memory through its pins
`timescale 1ns/1ps
module asr_host import asr_pkg::*; (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// User request
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [DATA_W-1:0] reqWdata,
	output logic                   reqReady,
	// User response
	output logic                   rspValid,
	output logic [DATA_W-1:0]      rspRdata,
	// Memory pins
	output logic [ADDR_W-1:0]      sramAddr,
	output logic                   selectLowActiveN,
	output logic                   selectHighActive,
	output logic                   outEnableN,
	output logic                   writeEnableN,
	output logic [DATA_W-1:0]      dqOut,
	output logic                   dqOeN,
	input  wire logic [DATA_W-1:0] dqIn
);
	logic              rstSync1_reg;
	logic              rstSync2_reg;
	logic              rstSyncN;
	logic [DATA_W-1:0] dqSync1_reg;
	logic [DATA_W-1:0] dqSync2_reg;
	asr_state_e        state_reg;
	asr_state_e        state_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic              sel_next;
	logic              selLowN_reg;
	logic              selHigh_reg;
	logic              oeN_reg;
	logic              oeN_next;
	logic              weN_reg;
	logic              weN_next;
	logic [DATA_W-1:0] dqOut_reg;
	logic [DATA_W-1:0] dqOut_next;
	logic              dqOeN_reg;
	logic              dqOeN_next;
	logic              ready_reg;
	logic              rsp_reg;
	logic              rsp_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [7:0]        addrAge_reg;
	logic [7:0]        weLow_reg;
	logic [7:0]        dataAge_reg;
	logic              selected;

	asr_timer_if tmr ();

	asr_timer u_timer (
		.sys_clk  (sys_clk),
		.rstSyncN (rstSyncN),
		.tmr      (tmr.timer)
	);

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1_reg <= 1'b0;
			rstSync2_reg <= 1'b0;
		end else begin
			rstSync1_reg <= 1'b1;
			rstSync2_reg <= rstSync1_reg;
		end
	end
	assign rstSyncN = rstSync2_reg;

	// Data pins come from outside the clock domain
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			dqSync1_reg <= 8'h00;
			dqSync2_reg <= 8'h00;
		end else begin
			dqSync1_reg <= dqIn;
			dqSync2_reg <= dqSync1_reg;
		end
	end

	// Sequencer; output enable stays high through writes so the memory never drives against us
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		sel_next = !selLowN_reg;
		oeN_next = oeN_reg;
		weN_next = weN_reg;
		dqOut_next = dqOut_reg;
		dqOeN_next = dqOeN_reg;
		rsp_next = 1'b0;
		rdata_next = rdata_reg;
		tmr.load = 1'b0;
		tmr.loadValue = 8'h00;
		case (state_reg)
			ST_IDLE: begin
				if (reqValid && ready_reg) begin
					addr_next = reqAddr; // address set in the same edge as the select
					sel_next = 1'b1;
					tmr.load = 1'b1;
					if (reqWrite) begin
						weN_next = 1'b0;
						dqOut_next = reqWdata;
						dqOeN_next = 1'b0;
						tmr.loadValue = TMR_W'(WE_LOW_CYC - 1);
						state_next = ST_WR_LOW;
					end else begin
						oeN_next = 1'b0;
						tmr.loadValue = TMR_W'(READ_CYC - 1);
						state_next = ST_READ;
					end
				end
			end
			ST_READ: begin
				if (tmr.expired) begin
					rdata_next = dqSync2_reg;
					rsp_next = 1'b1;
					sel_next = 1'b0;
					oeN_next = 1'b1;
					tmr.load = 1'b1;
					// Memory may still drive for its float time after deselect
					tmr.loadValue = TMR_W'(TURN_CYC - 1);
					state_next = ST_TURN;
				end
			end
			ST_WR_LOW: begin
				if (tmr.expired) begin
					weN_next = 1'b1;
					tmr.load = 1'b1;
					tmr.loadValue = TMR_W'(WR_REST_CYC - 1);
					state_next = ST_WR_HIGH;
				end
			end
			ST_WR_HIGH: begin
				if (tmr.expired) begin
					sel_next = 1'b0;
					dqOeN_next = 1'b1;
					rsp_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			ST_TURN: begin
				if (tmr.expired) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Sequencer state and pin registers
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_reg <= ST_IDLE;
			addr_reg <= 17'h00000;
			selLowN_reg <= 1'b1;
			selHigh_reg <= 1'b0;
			oeN_reg <= 1'b1;
			weN_reg <= 1'b1;
			dqOut_reg <= 8'h00;
			dqOeN_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			selLowN_reg <= !sel_next;
			selHigh_reg <= sel_next;
			oeN_reg <= oeN_next;
			weN_reg <= weN_next;
			dqOut_reg <= dqOut_next;
			dqOeN_reg <= dqOeN_next;
		end
	end

	// User handshake registers
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			ready_reg <= 1'b0;
			rsp_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			ready_reg <= (state_next == ST_IDLE) && !(state_reg == ST_IDLE && reqValid && ready_reg);
			rsp_reg <= rsp_next;
			rdata_reg <= rdata_next;
		end
	end

	// Saturating ages of the pin phases, read by the checks below
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			addrAge_reg <= 8'hff;
			weLow_reg <= 8'h00;
			dataAge_reg <= 8'h00;
		end else begin
			addrAge_reg <= (addr_next != addr_reg) ? 8'h01 : addrAge_reg + {7'h00, addrAge_reg != 8'hff};
			weLow_reg <= weN_next ? 8'h00 : weLow_reg + {7'h00, weLow_reg != 8'hff};
			if (dqOeN_next || dqOut_next != dqOut_reg || dqOeN_reg) begin
				dataAge_reg <= dqOeN_next ? 8'h00 : 8'h01;
			end else begin
				dataAge_reg <= dataAge_reg + {7'h00, dataAge_reg != 8'hff};
			end
		end
	end

	assign selected = !selLowN_reg && selHigh_reg;

	property p_readWeHigh;
		@(posedge sys_clk) disable iff (!rstSyncN)
		(selected && !oeN_reg) |-> weN_reg;
	endproperty
	a_readWeHigh: assert property (p_readWeHigh) else $error("write enable low during a read");

	property p_noContention;
		@(posedge sys_clk) disable iff (!rstSyncN)
		!dqOeN_reg |-> (oeN_reg && !weN_reg) or (oeN_reg && !$past(dqOeN_reg));
	endproperty
	a_noContention: assert property (p_noContention) else $error("host drives bus while memory may");

	property p_cycleTime;
		@(posedge sys_clk) disable iff (!rstSyncN)
		$changed(addr_reg) |-> $past(addrAge_reg) >= CYCLE_CYC;
	endproperty
	a_cycleTime: assert property (p_cycleTime) else $error("address changed before cycle time");

	property p_readLength;
		@(posedge sys_clk) disable iff (!rstSyncN)
		$fell(oeN_reg) |-> (!oeN_reg && selected)[*6] ##1 (oeN_reg && rsp_reg);
	endproperty
	a_readLength: assert property (p_readLength) else $error("read phase length wrong");

	property p_addrStableSelected;
		@(posedge sys_clk) disable iff (!rstSyncN)
		(selected && $past(selected)) |-> $stable(addr_reg);
	endproperty
	a_addrStableSelected: assert property (p_addrStableSelected) else $error("address moved while selected");

	property p_writePulse;
		@(posedge sys_clk) disable iff (!rstSyncN)
		$rose(weN_reg) |-> $past(weLow_reg) >= WR_PULSE_CYC && $past(selected);
	endproperty
	a_writePulse: assert property (p_writePulse) else $error("write pulse too short");

	property p_addrToEnd;
		@(posedge sys_clk) disable iff (!rstSyncN)
		$rose(weN_reg) |-> $past(addrAge_reg) >= ADDR_END_CYC;
	endproperty
	a_addrToEnd: assert property (p_addrToEnd) else $error("address not held before write end");

	property p_dataSetup;
		@(posedge sys_clk) disable iff (!rstSyncN)
		$rose(weN_reg) |-> $past(dataAge_reg) >= DATA_SETUP_CYC && !dqOeN_reg;
	endproperty
	a_dataSetup: assert property (p_dataSetup) else $error("write data setup too short");

	property p_writeSelected;
		@(posedge sys_clk) disable iff (!rstSyncN)
		!weN_reg |-> selected && oeN_reg;
	endproperty
	a_writeSelected: assert property (p_writeSelected) else $error("write enable low outside select");

	assign reqReady = ready_reg;
	assign rspValid = rsp_reg;
	assign rspRdata = rdata_reg;
	assign sramAddr = addr_reg;
	assign selectLowActiveN = selLowN_reg;
	assign selectHighActive = selHigh_reg;
	assign outEnableN = oeN_reg;
	assign writeEnableN = weN_reg;
	assign dqOut = dqOut_reg;
	assign dqOeN = dqOeN_reg;
endmodule

/* File: asr_sram_model.sv */
// Behavioural model of the 128K x 8 asynchronous static memory behind the host
`timescale 1ns/1ps
module asr_sram_model import asr_pkg::*; #(
	parameter int T_ACC_NS = 35,
	parameter int T_CYC_NS = 35,
	parameter int T_WP_NS  = 20,
	parameter int T_DS_NS  = 11
) (
	// Memory pins
	input  wire logic [ADDR_W-1:0] sramAddr,
	input  wire logic              selectLowActiveN,
	input  wire logic              selectHighActive,
	input  wire logic              outEnableN,
	input  wire logic              writeEnableN,
	input  wire logic [DATA_W-1:0] dqWire,
	output logic [DATA_W-1:0]      dqDrive,
	output logic                   dqDriveOeN,
	// Timing faults of the host
	output int                     violations
);
	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic              selected;
	logic              readOn;
	logic              writeOn;
	// Address and write starts set at declaration so pin events at time zero never see a start of 0.0; data time starts at 0.0
	realtime           addrTime = -1000.0;
	realtime           dataTime = 0.0;
	realtime           wrStart = -1.0;
	assign selected = !selectLowActiveN && selectHighActive;
	assign readOn = selected && !outEnableN && writeEnableN;
	assign writeOn = selected && !writeEnableN;
	initial begin
		dqDrive = '0;
		dqDriveOeN = 1'b1;
		violations = 0;
	end
	// Turn-on waits the least enable-to-active time; turn-off is at once, inside the float limit
	always @(readOn) begin
		if (readOn) dqDriveOeN <= #5 1'b0;
		else dqDriveOeN <= 1'b1;
	end
	// Old byte held briefly, then unknown until access time has run
	always @(sramAddr or selected) begin
		dqDrive <= #3 'x;
		dqDrive <= #(T_ACC_NS) mem[sramAddr];
	end
	always @(sramAddr) begin
		if ($realtime - addrTime < T_CYC_NS) violations++;
		addrTime = $realtime;
	end
	always @(dqWire) dataTime = $realtime;
	always @(posedge writeOn) wrStart = $realtime;
	// Byte stored as the overlap ends; a start of -1 means no overlap was seen
	always @(negedge writeOn) begin
		if (wrStart >= 0.0) begin
			if ($realtime - wrStart < T_WP_NS) violations++;
			if ($realtime - dataTime < T_DS_NS) violations++;
			if ($realtime - addrTime < T_WP_NS) violations++;
			mem[sramAddr] = dqWire;
		end
		wrStart = -1.0;
	end
endmodule

/* File: test_async_sram_128k_by_8.sv */
// Self-checking bench: host controller against the behavioural static memory
`timescale 1ns/1ps
module test_async_sram_128k_by_8 import asr_pkg::*;;
	logic              sys_clk = 1'b0;
	logic              rst_n;
	logic              reqValid;
	logic              reqWrite;
	logic [ADDR_W-1:0] reqAddr;
	logic [DATA_W-1:0] reqWdata;
	logic              reqReady;
	logic              rspValid;
	logic [DATA_W-1:0] rspRdata;
	logic [ADDR_W-1:0] sramAddr;
	logic              selectLowActiveN;
	logic              selectHighActive;
	logic              outEnableN;
	logic              writeEnableN;
	logic [DATA_W-1:0] dqOut;
	logic              dqOeN;
	logic [DATA_W-1:0] dqWire;
	logic [DATA_W-1:0] memData;
	logic              memOeN;
	logic [DATA_W-1:0] floatPat = 8'h5a;
	int                memViol;
	int                failures = 0;
	int                numChecks = 0;
	// No pull on the data lines: a released bus shows a pattern that moves every cycle
	assign dqWire = (!dqOeN && !memOeN) ? 'x : !dqOeN ? dqOut : !memOeN ? memData : floatPat;
	always @(posedge sys_clk) floatPat <= floatPat + 8'h3b;
	always #5 sys_clk = ~sys_clk;
	asr_host asr_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
		.sramAddr(sramAddr), .selectLowActiveN(selectLowActiveN), .selectHighActive(selectHighActive),
		.outEnableN(outEnableN), .writeEnableN(writeEnableN), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqWire));
	asr_sram_model asr_sram_model_inst (.sramAddr(sramAddr), .selectLowActiveN(selectLowActiveN),
		.selectHighActive(selectHighActive), .outEnableN(outEnableN), .writeEnableN(writeEnableN),
		.dqWire(dqWire), .dqDrive(memData), .dqDriveOeN(memOeN), .violations(memViol));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge sys_clk) if (rst_n === 1'b1) begin
		check("selects opposite", selectLowActiveN, !selectHighActive);
		if (outEnableN === 1'b0) check("write strobe in read", writeEnableN, 1'b1);
	end
	// One request, possibly raised while not ready so the refusal path is used as well
	task automatic do_req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		reqValid = 1'b1;
		reqWrite = wr;
		reqAddr = a;
		reqWdata = d;
		n = 0;
		while (reqReady !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		@(posedge sys_clk);
		#1;
		reqValid = 1'b0;
		check("ready after take", reqReady, 1'b0);
		check("address pins", sramAddr, a);
		check("selected", {selectLowActiveN, selectHighActive}, 2'b01);
		check("write strobe", writeEnableN, !wr);
		check("output enable", outEnableN, wr);
		check("host drives", dqOeN, !wr);
		if (wr) check("write data", dqOut, d);
		n = 0;
		while (rspValid !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check("answer latency", n, wr ? WE_LOW_CYC + WR_REST_CYC : READ_CYC);
		check("released after cycle", {dqOeN, outEnableN, selectLowActiveN}, 3'b111);
		if (!wr) check("read data", rspRdata, d);
	endtask
	task automatic test_reset();
		rst_n = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		check("pins in reset", {selectLowActiveN, selectHighActive, outEnableN, writeEnableN, dqOeN}, 5'h17);
		rst_n = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check("ready one edge early", reqReady, 1'b0);
		@(posedge sys_clk);
		#1;
		check("ready after release", reqReady, 1'b1);
	endtask
	logic [ADDR_W-1:0] addrTab [6] = '{17'h00000, 17'h1ffff, 17'h10000, 17'h0ffff, 17'h15555, 17'h0aaaa};
	logic [DATA_W-1:0] dataTab [6] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01, 8'h80};
	task automatic test_table();
		for (int i = 0; i < 6; i++) do_req(1'b1, addrTab[i], dataTab[i]);
		for (int i = 5; i >= 0; i--) do_req(1'b0, addrTab[i], dataTab[i]);
	endtask
	task automatic test_overwrite();
		do_req(1'b1, 17'h00123, 8'h11);
		do_req(1'b1, 17'h00123, 8'hee);
		do_req(1'b0, 17'h00123, 8'hee);
		do_req(1'b0, 17'h1ffff, 8'hff);
	endtask
	// Abort a read of address 0 under way, so the address pins do not move under the reset
	task automatic test_midrun_reset();
		int n;
		reqValid = 1'b1;
		reqWrite = 1'b0;
		reqAddr = '0;
		n = 0;
		while (reqReady !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		@(posedge sys_clk);
		#1;
		reqValid = 1'b0;
		check("abort read under way", {outEnableN, selectHighActive}, 2'b01);
		@(posedge sys_clk);
		#1;
		rst_n = 1'b0;
		#1;
		check("pins after abort", {selectLowActiveN, selectHighActive, outEnableN, dqOeN}, 4'hb);
		check("ready in abort", reqReady, 1'b0);
		@(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		do_req(1'b0, 17'h10000, 8'h5a);
	endtask
	initial begin
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = '0;
		reqWdata = '0;
		test_reset();
		test_table();
		test_overwrite();
		test_midrun_reset();
		check("memory timing faults", memViol, 0);
		finish_test();
	end
	initial begin
		#100000;
		failures++;
		finish_test();
	end
endmodule
